// ### src/dbuf_field.sv
`timescale 1ns/1ps
`default_nettype none
module dbuf_field #(
  parameter int unsigned MAX_W = 15,
  parameter int unsigned FIELD_W = 15,
  parameter logic [14:0] RESET_VAL = 15'h0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host side
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wr_data,
  input wire logic commit,
  // Copies
  output logic [MAX_W-1:0] shadow,
  output logic [MAX_W-1:0] active
);

  localparam logic [MAX_W-1:0] MASK = MAX_W'((1 << FIELD_W) - 1);

  logic [MAX_W-1:0] next_shadow;
  logic [MAX_W-1:0] next_active;

  // ----------------------------------------
  // Shadow and active copies
  // ----------------------------------------
  always_comb begin
    next_shadow = shadow;
    next_active = active;
    if (wr_low) begin
      next_shadow[7:0] = wr_data;
    end
    if (wr_high) begin
      next_shadow[MAX_W-1:8] = wr_data[MAX_W-9:0];
    end
    next_shadow = next_shadow & MASK;
    // Commit takes the shadow as it stood before any same-cycle write
    if (commit) begin
      next_active = shadow;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow <= RESET_VAL & MASK;
      active <= RESET_VAL & MASK;
    end else begin
      shadow <= next_shadow;
      active <= next_active;
    end
  end

endmodule
`default_nettype wire

// ### src/divcfg_pkg.sv
// What this block does
// - A fixed 16-bit vendor code reads back as its low byte at 0x0C and its high byte at 0x0D.
// - Every divider or threshold field wider than eight bits has a host-written shadow copy and an active copy.
// - Writing 1 to the commit bit copies all shadow copies into the active copies at once; the bit self-clears.
// - Only the active copies drive device operation, so shadow writes do nothing until a commit.
// - The lock-flag level select resets to 0 for 1.8 V, and 1 selects 3.3 V.
// - The interrupt and lock level select resets to 1 for 3.3 V, and 0 selects 1.8 V.
// - The serial data pin level select resets to 0 for 1.8 V, and 1 selects 3.3 V.
// - The read-back select returns active copies when 0 and shadow copies when 1.
package divcfg_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIELD_MAX_W = 15;
  localparam int unsigned NUM_FIELDS = 7;

  // ----------------------------------------
  // Field indices
  // ----------------------------------------
  localparam int unsigned FLD_PREDIV_A = 0;
  localparam int unsigned FLD_PREDIV_B = 1;
  localparam int unsigned FLD_FIRST_FB = 2;
  localparam int unsigned FLD_LOCK_WIN = 3;
  localparam int unsigned FLD_SECOND_FB = 4;
  localparam int unsigned FLD_MON_A = 5;
  localparam int unsigned FLD_MON_B = 6;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_VENDOR_LOW = 8'h0C;
  localparam logic [7:0] OFS_VENDOR_HIGH = 8'h0D;
  localparam logic [7:0] OFS_CONTROL = 8'h0E;

  // Low-byte offset of each field; the high byte sits at the next address
  localparam logic [7:0] FIELD_LO_OFS [NUM_FIELDS] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h1A, 8'h1C, 8'h1E};
  localparam int unsigned FIELD_WIDTH [NUM_FIELDS] = '{15, 15, 15, 15, 9, 15, 15};
  localparam logic [14:0] FIELD_RESET [NUM_FIELDS] = '{15'h0008, 15'h0008, 15'h0008, 15'h0003,
                                                       15'h0000, 15'h0000, 15'h0000};

  // ----------------------------------------
  // Control register bits
  // ----------------------------------------
  localparam int unsigned BIT_SERIAL_LVL = 0;
  localparam int unsigned BIT_IRQ_LOCK_LVL = 1;
  localparam int unsigned BIT_LOCK_FLAG_LVL = 2;
  localparam int unsigned BIT_READBACK = 3;
  localparam int unsigned BIT_COMMIT = 7;

  localparam logic RST_SERIAL_LVL = 1'b0;
  localparam logic RST_IRQ_LOCK_LVL = 1'b1;
  localparam logic RST_LOCK_FLAG_LVL = 1'b0;
  localparam logic RST_READBACK = 1'b0;

  // Arbitrary neutral identification value
  localparam logic [15:0] VENDOR_CODE_DEFAULT = 16'h5A3C;

endpackage

// ### src/divider_commit_and_io_level_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module divider_commit_and_io_level_cfg
  import divcfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = divcfg_pkg::VENDOR_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register access port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [divcfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [divcfg_pkg::DATA_W-1:0] reg_wr_data,
  output logic [divcfg_pkg::DATA_W-1:0] reg_rd_data,
  // Active divider settings
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] input_prediv_a,
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] input_prediv_b,
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] first_loop_fb_div,
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] lock_window_threshold,
  output logic [8:0] second_loop_fb_div,
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] monitor_div_a,
  output logic [divcfg_pkg::FIELD_MAX_W-1:0] monitor_div_b,
  output logic commit_pulse,
  // Pad level selects
  output logic lock_flag_level_select,
  output logic irq_lock_level_select,
  output logic serial_pin_level_select
);

  import divcfg_pkg::*;

  logic [FIELD_MAX_W-1:0] shadow_val [NUM_FIELDS];
  logic [FIELD_MAX_W-1:0] active_val [NUM_FIELDS];
  logic [FIELD_MAX_W-1:0] rb_val [NUM_FIELDS];
  logic [NUM_FIELDS-1:0] hit_low;
  logic [NUM_FIELDS-1:0] hit_high;
  logic readback_select;
  logic next_lock_flag;
  logic next_irq_lock;
  logic next_serial;
  logic next_readback;
  logic next_commit;
  logic [DATA_W-1:0] next_rd_data;

  // ----------------------------------------
  // Double-buffered fields
  // ----------------------------------------
  // Input pre-divider A
  assign hit_low[FLD_PREDIV_A] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_PREDIV_A]);
  assign hit_high[FLD_PREDIV_A] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_PREDIV_A] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_PREDIV_A]),
    .RESET_VAL(FIELD_RESET[FLD_PREDIV_A])
  ) u_prediv_a (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_PREDIV_A]),
    .wr_high(hit_high[FLD_PREDIV_A]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_PREDIV_A]),
    .active(active_val[FLD_PREDIV_A])
  );

  // Input pre-divider B
  assign hit_low[FLD_PREDIV_B] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_PREDIV_B]);
  assign hit_high[FLD_PREDIV_B] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_PREDIV_B] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_PREDIV_B]),
    .RESET_VAL(FIELD_RESET[FLD_PREDIV_B])
  ) u_prediv_b (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_PREDIV_B]),
    .wr_high(hit_high[FLD_PREDIV_B]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_PREDIV_B]),
    .active(active_val[FLD_PREDIV_B])
  );

  // First loop feedback divider
  assign hit_low[FLD_FIRST_FB] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_FIRST_FB]);
  assign hit_high[FLD_FIRST_FB] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_FIRST_FB] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_FIRST_FB]),
    .RESET_VAL(FIELD_RESET[FLD_FIRST_FB])
  ) u_first_fb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_FIRST_FB]),
    .wr_high(hit_high[FLD_FIRST_FB]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_FIRST_FB]),
    .active(active_val[FLD_FIRST_FB])
  );

  // Lock window threshold
  assign hit_low[FLD_LOCK_WIN] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_LOCK_WIN]);
  assign hit_high[FLD_LOCK_WIN] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_LOCK_WIN] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_LOCK_WIN]),
    .RESET_VAL(FIELD_RESET[FLD_LOCK_WIN])
  ) u_lock_win (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_LOCK_WIN]),
    .wr_high(hit_high[FLD_LOCK_WIN]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_LOCK_WIN]),
    .active(active_val[FLD_LOCK_WIN])
  );

  // Second loop feedback divider, nine bits wide
  assign hit_low[FLD_SECOND_FB] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_SECOND_FB]);
  assign hit_high[FLD_SECOND_FB] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_SECOND_FB] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_SECOND_FB]),
    .RESET_VAL(FIELD_RESET[FLD_SECOND_FB])
  ) u_second_fb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_SECOND_FB]),
    .wr_high(hit_high[FLD_SECOND_FB]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_SECOND_FB]),
    .active(active_val[FLD_SECOND_FB])
  );

  // Monitor divider A
  assign hit_low[FLD_MON_A] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_MON_A]);
  assign hit_high[FLD_MON_A] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_MON_A] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_MON_A]),
    .RESET_VAL(FIELD_RESET[FLD_MON_A])
  ) u_mon_a (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_MON_A]),
    .wr_high(hit_high[FLD_MON_A]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_MON_A]),
    .active(active_val[FLD_MON_A])
  );

  // Monitor divider B
  assign hit_low[FLD_MON_B] = reg_wr_en && (reg_addr == FIELD_LO_OFS[FLD_MON_B]);
  assign hit_high[FLD_MON_B] = reg_wr_en && (reg_addr == 8'(FIELD_LO_OFS[FLD_MON_B] + 8'h01));

  dbuf_field #(
    .MAX_W(FIELD_MAX_W),
    .FIELD_W(FIELD_WIDTH[FLD_MON_B]),
    .RESET_VAL(FIELD_RESET[FLD_MON_B])
  ) u_mon_b (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_low(hit_low[FLD_MON_B]),
    .wr_high(hit_high[FLD_MON_B]),
    .wr_data(reg_wr_data),
    .commit(commit_pulse),
    .shadow(shadow_val[FLD_MON_B]),
    .active(active_val[FLD_MON_B])
  );

  // Read-back picks the shadow or the active copy of each field
  for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_readback
    assign rb_val[i] = readback_select ? shadow_val[i] : active_val[i];
  end

  // Operation sees only the active copies
  assign input_prediv_a = active_val[FLD_PREDIV_A];
  assign input_prediv_b = active_val[FLD_PREDIV_B];
  assign first_loop_fb_div = active_val[FLD_FIRST_FB];
  assign lock_window_threshold = active_val[FLD_LOCK_WIN];
  assign second_loop_fb_div = active_val[FLD_SECOND_FB][8:0];
  assign monitor_div_a = active_val[FLD_MON_A];
  assign monitor_div_b = active_val[FLD_MON_B];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    next_lock_flag = lock_flag_level_select;
    next_irq_lock = irq_lock_level_select;
    next_serial = serial_pin_level_select;
    next_readback = readback_select;
    next_commit = 1'b0;
    if (reg_wr_en && (reg_addr == OFS_CONTROL)) begin
      next_lock_flag = reg_wr_data[BIT_LOCK_FLAG_LVL];
      next_irq_lock = reg_wr_data[BIT_IRQ_LOCK_LVL];
      next_serial = reg_wr_data[BIT_SERIAL_LVL];
      next_readback = reg_wr_data[BIT_READBACK];
      // Writing 0 leaves the copies alone; the bit never stores
      next_commit = reg_wr_data[BIT_COMMIT];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_flag_level_select <= RST_LOCK_FLAG_LVL;
      irq_lock_level_select <= RST_IRQ_LOCK_LVL;
      serial_pin_level_select <= RST_SERIAL_LVL;
      readback_select <= RST_READBACK;
      commit_pulse <= 1'b0;
    end else begin
      lock_flag_level_select <= next_lock_flag;
      irq_lock_level_select <= next_irq_lock;
      serial_pin_level_select <= next_serial;
      readback_select <= next_readback;
      commit_pulse <= next_commit;
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  // Vendor code decodes on reads only, so writes there fall away
  always_comb begin
    next_rd_data = reg_rd_data;
    if (reg_rd_en) begin
      next_rd_data = 8'h00;
      case (reg_addr)
        OFS_VENDOR_LOW: begin
          next_rd_data = VENDOR_CODE[7:0];
        end
        OFS_VENDOR_HIGH: begin
          next_rd_data = VENDOR_CODE[15:8];
        end
        OFS_CONTROL: begin
          next_rd_data[BIT_LOCK_FLAG_LVL] = lock_flag_level_select;
          next_rd_data[BIT_IRQ_LOCK_LVL] = irq_lock_level_select;
          next_rd_data[BIT_SERIAL_LVL] = serial_pin_level_select;
          next_rd_data[BIT_READBACK] = readback_select;
        end
        FIELD_LO_OFS[FLD_PREDIV_A]: begin
          next_rd_data = rb_val[FLD_PREDIV_A][7:0];
        end
        8'(FIELD_LO_OFS[FLD_PREDIV_A] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_PREDIV_A][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_PREDIV_B]: begin
          next_rd_data = rb_val[FLD_PREDIV_B][7:0];
        end
        8'(FIELD_LO_OFS[FLD_PREDIV_B] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_PREDIV_B][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_FIRST_FB]: begin
          next_rd_data = rb_val[FLD_FIRST_FB][7:0];
        end
        8'(FIELD_LO_OFS[FLD_FIRST_FB] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_FIRST_FB][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_LOCK_WIN]: begin
          next_rd_data = rb_val[FLD_LOCK_WIN][7:0];
        end
        8'(FIELD_LO_OFS[FLD_LOCK_WIN] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_LOCK_WIN][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_SECOND_FB]: begin
          next_rd_data = rb_val[FLD_SECOND_FB][7:0];
        end
        8'(FIELD_LO_OFS[FLD_SECOND_FB] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_SECOND_FB][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_MON_A]: begin
          next_rd_data = rb_val[FLD_MON_A][7:0];
        end
        8'(FIELD_LO_OFS[FLD_MON_A] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_MON_A][FIELD_MAX_W-1:8]};
        end
        FIELD_LO_OFS[FLD_MON_B]: begin
          next_rd_data = rb_val[FLD_MON_B][7:0];
        end
        8'(FIELD_LO_OFS[FLD_MON_B] + 8'h01): begin
          next_rd_data = {1'b0, rb_val[FLD_MON_B][FIELD_MAX_W-1:8]};
        end
        default: begin
          // Unmapped addresses and gaps between fields read as zero
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else begin
      reg_rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

// ### verif/divcfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module divcfg_asserts
  import divcfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h0000
) (
  // Clock, reset and register port
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  // Watched outputs
  input wire logic [14:0] input_prediv_a,
  input wire logic [8:0] second_loop_fb_div,
  input wire logic commit_pulse,
  input wire logic lock_flag_level_select,
  input wire logic irq_lock_level_select,
  input wire logic serial_pin_level_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic ctl_wr = reg_wr_en && reg_addr == OFS_CONTROL;
  wire logic [2:0] lvl = {lock_flag_level_select, irq_lock_level_select, serial_pin_level_select};
  vend_low_a: assert property (reg_rd_en && reg_addr == 8'h0C |=> reg_rd_data == VENDOR_CODE[7:0])
    else $error("vendor low byte wrong");
  vend_high_a: assert property (reg_rd_en && reg_addr == 8'h0D |=> reg_rd_data == VENDOR_CODE[15:8])
    else $error("vendor high byte wrong");
  commit_start_a: assert property (ctl_wr && reg_wr_data[7] |=> commit_pulse)
    else $error("commit write gave no pulse");
  commit_quiet_a: assert property (!(ctl_wr && reg_wr_data[7]) |=> !commit_pulse)
    else $error("pulse without commit write");
  active_hold_a: assert property (!$past(commit_pulse) |-> $stable({input_prediv_a, second_loop_fb_div}))
    else $error("active copy moved without commit");
  level_load_a: assert property (ctl_wr |=> lvl == $past(reg_wr_data[2:0]))
    else $error("level selects not loaded");
  level_hold_a: assert property (!ctl_wr |=> $stable(lvl))
    else $error("level selects changed");
  unmapped_rd_a: assert property (reg_rd_en && reg_addr == 8'hFF |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind divider_commit_and_io_level_cfg divcfg_asserts #(
  .VENDOR_CODE(VENDOR_CODE)
) chk_i (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data),
  .input_prediv_a(input_prediv_a),
  .second_loop_fb_div(second_loop_fb_div),
  .commit_pulse(commit_pulse),
  .lock_flag_level_select(lock_flag_level_select),
  .irq_lock_level_select(irq_lock_level_select),
  .serial_pin_level_select(serial_pin_level_select)
);
`default_nettype wire

// ### verif/divider_commit_and_io_level_cfg_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module divider_commit_and_io_level_cfg_tb_top;
  import divcfg_pkg::*;
  // Arbitrary test value
  localparam logic [15:0] VCODE = 16'hC3A5;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic reg_wr_en, reg_rd_en;
  wire logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [14:0] input_prediv_a, input_prediv_b, first_loop_fb_div, lock_window_threshold, monitor_div_a, monitor_div_b;
  logic [8:0] second_loop_fb_div;
  logic commit_pulse, lock_flag_level_select, irq_lock_level_select, serial_pin_level_select;
  wire logic [2:0] lvl = {lock_flag_level_select, irq_lock_level_select, serial_pin_level_select};
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] d;
  host_model host (.*);
  divider_commit_and_io_level_cfg #(.VENDOR_CODE(VCODE)) dut (.*);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  // ----
  // Helpers
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task do_reset;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    chk("levels", lvl, 3'b010);
    chk("pa_pb", {input_prediv_a, input_prediv_b}, {15'h0008, 15'h0008});
    chk("fb_th", {first_loop_fb_div, lock_window_threshold}, {15'h0008, 15'h0003});
    chk("fb2", second_loop_fb_div, 9'h000);
    chk("mon", {monitor_div_a, monitor_div_b}, 30'h00000000);
    chk("pulse", commit_pulse, 1'b0);
    $display("t_reset done");
  endtask
  task t_vendor;
    host.wr(OFS_VENDOR_LOW, 8'hFF);
    host.wr(OFS_VENDOR_HIGH, 8'h00);
    host.rd(OFS_VENDOR_LOW, d);
    chk("vend_lo", d, VCODE[7:0]);
    host.rd(OFS_VENDOR_HIGH, d);
    chk("vend_hi", d, VCODE[15:8]);
    host.rd(8'hFF, d);
    chk("unmapped", d, 8'h00);
    $display("t_vendor done");
  endtask
  task t_dbuf;
    host.wr(8'h10, 8'h34);
    host.wr(8'h11, 8'h92);
    host.wr(8'h1A, 8'hFF);
    host.wr(8'h1B, 8'hFF);
    chk("pa_idle", input_prediv_a, 15'h0008);
    host.rd(8'h10, d);
    chk("rb_act", d, 8'h08);
    host.wr(OFS_CONTROL, 8'h0A);
    host.rd(8'h11, d);
    chk("rb_shd", d, 8'h12);
    host.wr(OFS_CONTROL, 8'h8A);
    #1;
    chk("pulse_on", commit_pulse, 1'b1);
    @(posedge ref_clk);
    #1;
    chk("pulse_off", commit_pulse, 1'b0);
    chk("pa_act", input_prediv_a, 15'h1234);
    chk("fb2_act", second_loop_fb_div, 9'h1FF);
    host.rd(OFS_CONTROL, d);
    chk("ctl", d, 8'h0A);
    $display("t_dbuf done");
  endtask
  task t_fields;
    host.wr(8'h12, 8'h11);
    host.wr(8'h13, 8'hA2);
    host.wr(8'h14, 8'h33);
    host.wr(8'h15, 8'h44);
    host.wr(8'h16, 8'h55);
    host.wr(8'h17, 8'h66);
    host.wr(8'h1C, 8'h77);
    host.wr(8'h1D, 8'h08);
    host.wr(8'h1E, 8'h99);
    host.wr(8'h1F, 8'h7A);
    chk("pb_idle", input_prediv_b, 15'h0008);
    host.wr(OFS_CONTROL, 8'h80);
    @(posedge ref_clk);
    #1;
    chk("pb_act", input_prediv_b, 15'h2211);
    chk("fb_act", first_loop_fb_div, 15'h4433);
    chk("th_act", lock_window_threshold, 15'h6655);
    chk("mon_act", {monitor_div_a, monitor_div_b}, {15'h0877, 15'h7A99});
    host.rd(8'h13, d);
    chk("rb_hi", d, 8'h22);
    host.rd(8'h1B, d);
    chk("rb_fb2", d, 8'h01);
    $display("t_fields done");
  endtask
  task t_levels;
    for (int i = 0; i < 3; i++) begin
      host.wr(OFS_CONTROL, 8'h01 << i);
      #1;
      chk("lvl", lvl, 32'h1 << i);
    end
    // Reset in mid-run must restore defaults
    do_reset;
    t_reset;
    $display("t_levels done");
  endtask
  initial begin
    do_reset;
    t_reset;
    t_vendor;
    t_dbuf;
    t_fields;
    t_levels;
    final_report;
  end
endmodule
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and read data
  input wire logic ref_clk,
  input wire logic [7:0] reg_rd_data,
  // Request lines
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // Idle lines show the inverse so stale values never look valid
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~v;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rd_data;
  endtask
endmodule
`default_nettype wire
